// *** design/aotc_pkg.sv ***
// constants, field layout and carrier types for the output test configuration block
package aotc_pkg;
  localparam int NCH = 8;
  localparam int DW = 14;
  localparam int AW = 13;

  // register addresses on the serial control port
  localparam logic [AW-1:0] ADDR_IDX2 = 13'h004;
  localparam logic [AW-1:0] ADDR_IDX1 = 13'h005;
  localparam logic [AW-1:0] ADDR_CLKDIV = 13'h00B;
  localparam logic [AW-1:0] ADDR_ENH = 13'h00C;
  localparam logic [AW-1:0] ADDR_TEST = 13'h00D;
  localparam logic [AW-1:0] ADDR_OFFS = 13'h010;
  localparam logic [AW-1:0] ADDR_OMODE = 13'h014;

  // reset values
  localparam logic [7:0] IDX2_RST = 8'h0F;
  localparam logic [7:0] IDX1_RST = 8'h3F;
  localparam logic [7:0] CLKDIV_RST = 8'h00;
  localparam logic [7:0] ENH_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;
  localparam logic [7:0] OFFS_RST = 8'h00;
  localparam logic [7:0] OMODE_RST = 8'h01;

  // field positions
  localparam int DIV_W = 3;
  localparam int CHOP_BIT = 2;
  localparam int PNL_RST_BIT = 5;
  localparam int PNS_RST_BIT = 4;
  localparam int SEQ_LSB = 6;
  localparam int FMT_BIT = 0;
  localparam int INV_BIT = 2;
  localparam int LVDS_OPT_BIT = 6;
  localparam int IDX_DATA_W = 4;
  localparam int IDX1_CLK_W = 6;

  // output test codes
  localparam logic [3:0] TM_OFF = 4'h0;
  localparam logic [3:0] TM_MID = 4'h1;
  localparam logic [3:0] TM_PFS = 4'h2;
  localparam logic [3:0] TM_NFS = 4'h3;
  localparam logic [3:0] TM_CHK = 4'h4;
  localparam logic [3:0] TM_PN23 = 4'h5;
  localparam logic [3:0] TM_PN9 = 4'h6;
  localparam logic [3:0] TM_WTOG = 4'h7;
  localparam logic [3:0] TM_USER = 4'h8;
  localparam logic [3:0] TM_BTOG = 4'h9;
  localparam logic [3:0] TM_SYNC = 4'hA;
  localparam logic [3:0] TM_ONE = 4'hB;
  localparam logic [3:0] TM_MIX = 4'hC;

  // user sequencing codes
  localparam logic [1:0] SEQ_SINGLE = 2'h0;
  localparam logic [1:0] SEQ_ALT = 2'h1;
  localparam logic [1:0] SEQ_SINGLE_ONCE = 2'h2;
  localparam logic [1:0] SEQ_ALT_ONCE = 2'h3;
  localparam logic [1:0] ONCE_DONE = 2'h2;

  // fixed test words
  localparam logic [DW-1:0] PAT_MID = 14'h2000;
  localparam logic [DW-1:0] PAT_ONES = 14'h3FFF;
  localparam logic [DW-1:0] PAT_ZERO = 14'h0000;
  localparam logic [DW-1:0] PAT_CHK_A = 14'h2AAA;
  localparam logic [DW-1:0] PAT_CHK_B = 14'h1555;
  localparam logic [DW-1:0] PAT_SYNC = 14'h007F;
  localparam logic [DW-1:0] PAT_ONE = 14'h0001;
  localparam logic [DW-1:0] PAT_MIX = 14'h0F33;
  localparam logic [DW-1:0] SMAX = 14'h1FFF;
  localparam logic [DW-1:0] SMIN = 14'h2000;

  // sequence generators
  localparam int PN23_LEN = 23;
  localparam int PN23_TAP = 18;
  localparam int PN9_LEN = 9;
  localparam int PN9_TAP = 5;
  localparam logic [PN23_LEN-1:0] PN23_SEED = 23'h7FFFFF;
  localparam logic [PN9_LEN-1:0] PN9_SEED = 9'h1FF;

  // serial port framing
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam int RW_BIT = 14;

  typedef enum logic [1:0] {SP_IDLE, SP_INSTR, SP_DATA} aotc_spi_st_t;

  typedef struct packed {
    logic [1:0] user_seq;
    logic [3:0] test_mode;
    logic [7:0] offset;
    logic invert;
  } aotc_chan_cfg_t;
endpackage

// *** design/aotc_chan.sv ***
// one channel: offset trim, output format and test word generation
`timescale 1ns/1ps
`default_nettype none
module aotc_chan
  import aotc_pkg::*;
(
  // clock and control
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic smp_stb,
  // shared settings and this channel's own configuration
  input wire logic pn_long_rst,
  input wire logic pn_short_rst,
  input wire logic twos_fmt,
  input wire logic [15:0] user_pat1,
  input wire logic [15:0] user_pat2,
  input wire aotc_pkg::aotc_chan_cfg_t cfg,
  // data
  input wire logic [aotc_pkg::DW-1:0] conv_data,
  output logic [aotc_pkg::DW-1:0] out_data,
  output logic out_valid
);
  import aotc_pkg::*;

  logic [PN23_LEN-1:0] pn23_q, pn23_d;
  logic [PN9_LEN-1:0] pn9_q, pn9_d;
  logic alt_q, alt_d;
  logic [DW-1:0] one_q, one_d;
  logic [1:0] once_q, once_d;
  logic [5:0] mode_prev_q, mode_prev_d;
  logic [DW-1:0] data_q, data_d;
  logic vld_q, vld_d;

  always_comb
  begin
    logic signed [DW:0] sum;
    logic [DW-1:0] norm;
    logic [DW-1:0] word;
    logic [DW-1:0] upat;
    sum = '0;
    norm = '0;
    word = '0;
    upat = '0;
    pn23_d = pn23_q;
    pn9_d = pn9_q;
    alt_d = alt_q;
    one_d = one_q;
    once_d = once_q;
    mode_prev_d = {cfg.user_seq, cfg.test_mode};
    data_d = data_q;
    vld_d = smp_stb;
    // trim added before formatting, saturating at the signed range
    sum = $signed({conv_data[DW-1], conv_data}) +
          $signed({{(DW-7){cfg.offset[7]}}, cfg.offset});
    if (sum[DW] != sum[DW-1])
      norm = sum[DW] ? SMIN : SMAX;
    else
      norm = sum[DW-1:0];
    if (!twos_fmt)
      norm[DW-1] = ~norm[DW-1];
    // user words are 16 bits wide; the top bits reach the output
    if (!alt_q)
      upat = user_pat1[15:16-DW];
    else
      upat = user_pat2[15:16-DW];
    unique case (cfg.test_mode)
      TM_OFF: word = norm;
      TM_MID: word = PAT_MID;
      TM_PFS: word = PAT_ONES;
      TM_NFS: word = PAT_ZERO;
      TM_CHK: word = alt_q ? PAT_CHK_B : PAT_CHK_A;
      TM_PN23: word = pn23_q[PN23_LEN-1 -: DW];
      TM_PN9: word = {pn9_q, pn9_q[PN9_LEN-1 -: DW-PN9_LEN]};
      TM_WTOG: word = alt_q ? PAT_ZERO : PAT_ONES;
      TM_USER:
      begin
        unique case (cfg.user_seq)
          SEQ_SINGLE: word = user_pat1[15:16-DW];
          SEQ_ALT: word = upat;
          SEQ_SINGLE_ONCE: word = (once_q == 2'h0) ? user_pat1[15:16-DW] : PAT_ZERO;
          SEQ_ALT_ONCE: word = (once_q != ONCE_DONE) ? upat : PAT_ZERO;
        endcase
      end
      TM_BTOG: word = PAT_CHK_A;
      TM_SYNC: word = PAT_SYNC;
      TM_ONE: word = one_q;
      TM_MIX: word = alt_q ? ~PAT_MIX : PAT_MIX;
      default: word = norm;
    endcase
    if (smp_stb)
    begin
      data_d = cfg.invert ? ~word : word;
      pn23_d = {pn23_q[PN23_LEN-2:0], pn23_q[PN23_LEN-1] ^ pn23_q[PN23_TAP-1]};
      pn9_d = {pn9_q[PN9_LEN-2:0], pn9_q[PN9_LEN-1] ^ pn9_q[PN9_TAP-1]};
      alt_d = ~alt_q;
      one_d = {one_q[DW-2:0], one_q[DW-1]};
      if (once_q != ONCE_DONE)
        once_d = once_q + 2'h1;
    end
    // a new selection or sequencing restarts the playback and toggle phase,
    // otherwise a once mode written after another user mode would stay spent
    if ({cfg.user_seq, cfg.test_mode} != mode_prev_q)
    begin
      alt_d = 1'b0;
      once_d = 2'h0;
      one_d = PAT_ONE;
    end
    if (pn_long_rst)
      pn23_d = PN23_SEED;
    if (pn_short_rst)
      pn9_d = PN9_SEED;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pn23_q <= PN23_SEED;
      pn9_q <= PN9_SEED;
      alt_q <= 1'b0;
      one_q <= PAT_ONE;
      once_q <= 2'h0;
      mode_prev_q <= {SEQ_SINGLE, TM_OFF};
      data_q <= '0;
      vld_q <= 1'b0;
    end
    else if (ce)
    begin
      pn23_q <= pn23_d;
      pn9_q <= pn9_d;
      alt_q <= alt_d;
      one_q <= one_d;
      once_q <= once_d;
      mode_prev_q <= mode_prev_d;
      data_q <= data_d;
      vld_q <= vld_d;
    end
  end

  assign out_data = data_q;
  assign out_valid = vld_q;
endmodule
`default_nettype wire

// *** design/aotc_top.sv ***
// serial control port, configuration registers and sample clock divider
`timescale 1ns/1ps
`default_nettype none
module aotc_top
  import aotc_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // 3-wire serial control port
  input wire logic sclk_pin,
  input wire logic csb_pin,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_n,
  // sample clock and converter data
  input wire logic smp_clk_pin,
  input wire logic [aotc_pkg::NCH-1:0][aotc_pkg::DW-1:0] conv_data,
  input wire logic [15:0] user_pat1,
  input wire logic [15:0] user_pat2,
  // outputs
  output logic [aotc_pkg::NCH-1:0][aotc_pkg::DW-1:0] ch_data,
  output logic [aotc_pkg::NCH-1:0] ch_valid,
  output logic smp_stb,
  output logic chop_en,
  output logic lvds_reduced
);
  import aotc_pkg::*;

  // pin synchronisers
  logic sclk_m, sclk_s, sclk_p;
  logic csb_m, csb_s;
  logic sdi_m, sdi_s;
  logic smp_m, smp_s, smp_p;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_p <= 1'b0;
      csb_m <= 1'b1;
      csb_s <= 1'b1;
      sdi_m <= 1'b0;
      sdi_s <= 1'b0;
      smp_m <= 1'b0;
      smp_s <= 1'b0;
      smp_p <= 1'b0;
    end
    else if (ce)
    begin
      sclk_m <= sclk_pin;
      sclk_s <= sclk_m;
      sclk_p <= sclk_s;
      csb_m <= csb_pin;
      csb_s <= csb_m;
      sdi_m <= sdio_i;
      sdi_s <= sdi_m;
      smp_m <= smp_clk_pin;
      smp_s <= smp_m;
      smp_p <= smp_s;
    end
  end

  logic sclk_rise, sclk_fall, smp_rise;
  assign sclk_rise = sclk_s & ~sclk_p;
  assign sclk_fall = ~sclk_s & sclk_p;
  assign smp_rise = smp_s & ~smp_p;

  // serial engine and register state
  aotc_spi_st_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [14:0] sh_q, sh_d;
  logic rd_q, rd_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [7:0] tx_q, tx_d;
  logic sdo_q, sdo_d;
  logic oe_n_q, oe_n_d;
  logic [IDX_DATA_W-1:0] idx2_q, idx2_d;
  logic [IDX1_CLK_W-1:0] idx1_q, idx1_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic chop_q, chop_d;
  logic pnl_q, pnl_d;
  logic pns_q, pns_d;
  logic fmt_q, fmt_d;
  logic lvds_q, lvds_d;
  aotc_chan_cfg_t cfg_q [NCH];
  aotc_chan_cfg_t cfg_d [NCH];
  logic [DIV_W-1:0] dcnt_q, dcnt_d;
  logic stb_q, stb_d;

  // lowest selected channel answers reads, so all-selected gives channel A
  function automatic aotc_chan_cfg_t rd_cfg();
    aotc_chan_cfg_t c;
    logic [NCH-1:0] s;
    c = cfg_q[0];
    s = {idx2_q, idx1_q[IDX_DATA_W-1:0]};
    for (int i = NCH - 1; i >= 0; i--)
      if (s[i])
        c = cfg_q[i];
    return c;
  endfunction

  function automatic logic [7:0] rd_byte(input logic [AW-1:0] a);
    aotc_chan_cfg_t c;
    logic [7:0] b;
    c = rd_cfg();
    b = 8'h00;
    unique case (a)
      ADDR_IDX2: b = {4'h0, idx2_q};
      ADDR_IDX1: b = {2'h0, idx1_q};
      ADDR_CLKDIV: b = {5'h00, div_q};
      ADDR_ENH: b = {5'h00, chop_q, 2'h0};
      ADDR_TEST: b = {c.user_seq, pnl_q, pns_q, c.test_mode};
      ADDR_OFFS: b = c.offset;
      ADDR_OMODE: b = {1'b0, lvds_q, 3'h0, c.invert, 1'b0, fmt_q};
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  always_comb
  begin
    logic wr_en;
    logic [7:0] wr_data;
    logic [AW-1:0] wr_a;
    logic [NCH-1:0] sel;
    wr_en = 1'b0;
    wr_data = 8'h00;
    wr_a = addr_q;
    sel = {idx2_q, idx1_q[IDX_DATA_W-1:0]};
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rd_d = rd_q;
    addr_d = addr_q;
    tx_d = tx_q;
    sdo_d = sdo_q;
    oe_n_d = oe_n_q;
    if (csb_s)
    begin
      st_d = SP_IDLE;
      cnt_d = 4'h0;
      oe_n_d = 1'b1;
    end
    else
    begin
      if (sclk_rise)
      begin
        sh_d = {sh_q[13:0], sdi_s};
        cnt_d = cnt_q + 4'h1;
        unique case (st_q)
          SP_IDLE, SP_INSTR:
          begin
            st_d = SP_INSTR;
            if (cnt_q == INSTR_LAST)
            begin
              rd_d = sh_q[RW_BIT];
              addr_d = {sh_q[AW-2:0], sdi_s};
              tx_d = rd_byte({sh_q[AW-2:0], sdi_s});
              cnt_d = 4'h0;
              st_d = SP_DATA;
            end
          end
          SP_DATA:
          begin
            if (cnt_q == BYTE_LAST)
            begin
              wr_en = ~rd_q;
              wr_data = {sh_q[6:0], sdi_s};
              addr_d = addr_q - 13'h0001;
              tx_d = rd_byte(addr_q - 13'h0001);
              cnt_d = 4'h0;
            end
          end
        endcase
      end
      if (sclk_fall && st_q == SP_DATA && rd_q)
      begin
        sdo_d = tx_q[7];
        tx_d = {tx_q[6:0], 1'b0};
        oe_n_d = 1'b0;
      end
    end
    idx2_d = idx2_q;
    idx1_d = idx1_q;
    div_d = div_q;
    chop_d = chop_q;
    pnl_d = pnl_q;
    pns_d = pns_q;
    fmt_d = fmt_q;
    lvds_d = lvds_q;
    for (int i = 0; i < NCH; i++)
      cfg_d[i] = cfg_q[i];
    if (wr_en)
    begin
      unique case (wr_a)
        ADDR_IDX2: idx2_d = wr_data[IDX_DATA_W-1:0];
        ADDR_IDX1: idx1_d = wr_data[IDX1_CLK_W-1:0];
        ADDR_CLKDIV: div_d = wr_data[DIV_W-1:0];
        ADDR_ENH: chop_d = wr_data[CHOP_BIT];
        ADDR_TEST:
        begin
          pnl_d = wr_data[PNL_RST_BIT];
          pns_d = wr_data[PNS_RST_BIT];
        end
        ADDR_OMODE:
        begin
          fmt_d = wr_data[FMT_BIT];
          lvds_d = wr_data[LVDS_OPT_BIT];
        end
        default: ;
      endcase
      for (int i = 0; i < NCH; i++)
        if (sel[i])
        begin
          if (wr_a == ADDR_TEST)
          begin
            cfg_d[i].test_mode = wr_data[3:0];
            cfg_d[i].user_seq = wr_data[SEQ_LSB +: 2];
          end
          if (wr_a == ADDR_OFFS)
            cfg_d[i].offset = wr_data;
          if (wr_a == ADDR_OMODE)
            cfg_d[i].invert = wr_data[INV_BIT];
        end
    end
    // divider: one strobe every div+1 sample clock edges
    dcnt_d = dcnt_q;
    stb_d = 1'b0;
    if (smp_rise)
    begin
      if (dcnt_q >= div_q)
      begin
        dcnt_d = '0;
        stb_d = 1'b1;
      end
      else
        dcnt_d = dcnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q <= SP_IDLE;
      cnt_q <= 4'h0;
      sh_q <= '0;
      rd_q <= 1'b0;
      addr_q <= '0;
      tx_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_n_q <= 1'b1;
      idx2_q <= IDX2_RST[IDX_DATA_W-1:0];
      idx1_q <= IDX1_RST[IDX1_CLK_W-1:0];
      div_q <= CLKDIV_RST[DIV_W-1:0];
      chop_q <= ENH_RST[CHOP_BIT];
      pnl_q <= TEST_RST[PNL_RST_BIT];
      pns_q <= TEST_RST[PNS_RST_BIT];
      fmt_q <= OMODE_RST[FMT_BIT];
      lvds_q <= OMODE_RST[LVDS_OPT_BIT];
      for (int i = 0; i < NCH; i++)
        cfg_q[i] <= '{TEST_RST[SEQ_LSB +: 2], TEST_RST[3:0], OFFS_RST, OMODE_RST[INV_BIT]};
      dcnt_q <= '0;
      stb_q <= 1'b0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      tx_q <= tx_d;
      sdo_q <= sdo_d;
      oe_n_q <= oe_n_d;
      idx2_q <= idx2_d;
      idx1_q <= idx1_d;
      div_q <= div_d;
      chop_q <= chop_d;
      pnl_q <= pnl_d;
      pns_q <= pns_d;
      fmt_q <= fmt_d;
      lvds_q <= lvds_d;
      for (int i = 0; i < NCH; i++)
        cfg_q[i] <= cfg_d[i];
      dcnt_q <= dcnt_d;
      stb_q <= stb_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      aotc_chan u_chan (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .smp_stb(stb_q),
        .pn_long_rst(pnl_q),
        .pn_short_rst(pns_q),
        .twos_fmt(fmt_q),
        .user_pat1(user_pat1),
        .user_pat2(user_pat2),
        .cfg(cfg_q[g]),
        .conv_data(conv_data[g]),
        .out_data(ch_data[g]),
        .out_valid(ch_valid[g])
      );
    end
  endgenerate

  assign sdio_o = sdo_q;
  assign sdio_oe_n = oe_n_q;
  assign smp_stb = stb_q;
  assign chop_en = chop_q;
  assign lvds_reduced = lvds_q;
endmodule
`default_nettype wire

// *** tb/aotc_top_assertions.sv ***
// port checks for the output test configuration block
`timescale 1ns/1ps
`default_nettype none
module aotc_top_assertions
  import aotc_pkg::*;
(
  // clock and control
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // serial port
  input wire logic csb_pin,
  input wire logic sdio_o,
  input wire logic sdio_oe_n,
  // sample path and levels
  input wire logic smp_stb,
  input wire logic [aotc_pkg::NCH-1:0] ch_valid,
  input wire logic [aotc_pkg::NCH-1:0][aotc_pkg::DW-1:0] ch_data,
  input wire logic chop_en,
  input wire logic lvds_reduced
);
  default clocking cb @(posedge clk_sys);
  endclocking
  // a frozen enable stretches every pulse, so checks rest while ce is low
  default disable iff (rst || !ce);
  a_stb_single: assert property (smp_stb |=> !smp_stb)
    else $error("sample strobe longer than one cycle");
  a_valid_follow: assert property (smp_stb |=> ch_valid == {NCH{1'b1}})
    else $error("channel valid missing after sample strobe");
  a_valid_cause: assert property ((ch_valid != '0) |-> $past(smp_stb))
    else $error("channel valid without sample strobe");
  a_data_hold: assert property ((ch_valid == '0) |-> $stable(ch_data))
    else $error("channel data changed without valid");
  a_oe_idle: assert property (csb_pin [*6] |-> sdio_oe_n)
    else $error("serial data driven while deselected");
  a_oe_start: assert property ($fell(sdio_oe_n) |-> !csb_pin && $past(csb_pin, 4) == 1'b0)
    else $error("serial drive began outside a frame");
  a_dout_hold: assert property (csb_pin [*6] |=> $stable(sdio_o))
    else $error("serial data moved between frames");
  a_cfg_steady: assert property (csb_pin [*6] |=> $stable(chop_en) && $stable(lvds_reduced))
    else $error("configuration level moved between frames");
endmodule
`default_nettype wire

// *** tb/aotc_host.sv ***
// host side of the 3-wire serial control port
`timescale 1ns/1ps
`default_nettype none
module aotc_host (
  // clock
  input wire logic clk_sys,
  // serial port
  output logic sclk_pin,
  output logic csb_pin,
  output logic sdio_i,
  input wire logic sdio_o,
  input wire logic sdio_oe_n
);
  logic hbit;
  logic hen;
  // undriven wire has no pull: show the inverse, not a stale copy
  assign sdio_i = hen ? hbit : (sdio_oe_n ? ~hbit : sdio_o);
  initial
  begin
    sclk_pin = 1'b0;
    csb_pin = 1'b1;
    hbit = 1'b0;
    hen = 1'b1;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // slow sclk, six cycles a phase, so the synchronisers always see it
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
    output logic [7:0] rdat);
    logic [23:0] sh;
    sh = {rd, 2'b00, a, wd};
    rdat = 8'h00;
    csb_pin <= 1'b0;
    idle(6);
    for (int i = 23; i >= 0; i--)
    begin
      sclk_pin <= 1'b0;
      hen <= !(rd && i < 8);
      hbit <= sh[i];
      idle(6);
      sclk_pin <= 1'b1;
      rdat = {rdat[6:0], sdio_i};
      idle(6);
    end
    sclk_pin <= 1'b0;
    idle(6);
    csb_pin <= 1'b1;
    hen <= 1'b1;
    idle(12);
  endtask
endmodule
`default_nettype wire

// *** tb/tb_aotc_top.sv ***
// self-checking bench for the output test configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_aotc_top;
  import aotc_pkg::*;
  logic clk_sys, rst, ce, smp_clk_pin, sclk_pin, csb_pin, sdio_i, sdio_o, sdio_oe_n;
  logic smp_stb, chop_en, lvds_reduced;
  logic [NCH-1:0][DW-1:0] conv_data;
  logic [NCH-1:0][DW-1:0] ch_data;
  logic [NCH-1:0] ch_valid;
  logic [15:0] user_pat1, user_pat2;
  logic [DW-1:0] w0, w7, v0;
  logic [7:0] rd;
  logic [7:0] fc [5] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0A};
  logic [DW-1:0] fw [5] = '{14'h2000, 14'h3FFF, 14'h0000, 14'h2AAA, 14'h007F};
  int bad_count, cmp_count, stb_cnt;
  aotc_top aotc_top_inst (.clk_sys(clk_sys), .rst(rst), .ce(ce), .sclk_pin(sclk_pin),
    .csb_pin(csb_pin), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n),
    .smp_clk_pin(smp_clk_pin), .conv_data(conv_data), .user_pat1(user_pat1),
    .user_pat2(user_pat2), .ch_data(ch_data), .ch_valid(ch_valid), .smp_stb(smp_stb),
    .chop_en(chop_en), .lvds_reduced(lvds_reduced));
  aotc_host aotc_host_inst (.clk_sys(clk_sys), .sclk_pin(sclk_pin), .csb_pin(csb_pin),
    .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n));
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (smp_stb === 1'b1)
      stb_cnt <= stb_cnt + 1;
  task automatic give_verdict();
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    aotc_host_inst.xfer(1'b0, a, d, rd);
  endtask
  task automatic rchk(input logic [12:0] a, input logic [7:0] e);
    aotc_host_inst.xfer(1'b1, a, 8'h00, rd);
    cmp({8'h00, rd}, {8'h00, e});
  endtask
  // one sample edge; divider register must be at zero
  task automatic smp();
    int n;
    n = 0;
    smp_clk_pin <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (ch_valid[0] !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      bad_count++;
      give_verdict();
    end
    w0 = ch_data[0];
    w7 = ch_data[7];
    smp_clk_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic sx(input logic [DW-1:0] e0, input logic [DW-1:0] e7);
    smp();
    cmp(16'(w0), 16'(e0));
    cmp(16'(w7), 16'(e7));
  endtask
  // toggle phase restarts on a code change, yet only the pairing is checked
  task automatic alt(input logic [7:0] code, input logic [DW-1:0] a);
    wr(ADDR_TEST, code);
    smp();
    v0 = w0;
    smp();
    cmp(16'(w0 ^ v0), 16'h3FFF);
    cmp(16'(v0 == a || v0 == (a ^ 14'h3FFF)), 16'h0001);
  endtask
  // held generator shows its seed; once released, reference generators
  // step once per sample, long enough for zeros to reach the long word
  task automatic pn(input logic [7:0] code);
    logic [PN23_LEN-1:0] s23;
    logic [PN9_LEN-1:0] s9;
    logic [DW-1:0] e;
    s23 = PN23_SEED;
    s9 = PN9_SEED;
    wr(ADDR_TEST, code);
    sx(14'h3FFF, 14'h3FFF);
    sx(14'h3FFF, 14'h3FFF);
    wr(ADDR_TEST, code & 8'h0F);
    for (int n = 0; n < 16; n++)
    begin
      e = code[0] ? s23[22 -: 14] : {s9, s9[8 -: 5]};
      sx(e, e);
      s23 = {s23[21:0], s23[22] ^ s23[17]};
      s9 = {s9[7:0], s9[8] ^ s9[4]};
    end
  endtask
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    smp_clk_pin = 1'b0;
    conv_data = {NCH{14'h0123}};
    user_pat1 = 16'hA5A4;
    user_pat2 = 16'h1238;
    bad_count = 0;
    cmp_count = 0;
    stb_cnt = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rchk(ADDR_IDX2, 8'h0F);
    rchk(ADDR_IDX1, 8'h3F);
    rchk(ADDR_CLKDIV, 8'h00);
    rchk(ADDR_ENH, 8'h00);
    rchk(ADDR_TEST, 8'h00);
    rchk(ADDR_OFFS, 8'h00);
    rchk(ADDR_OMODE, 8'h01);
    rchk(13'h030, 8'h00);
    wr(ADDR_ENH, 8'h04);
    wr(ADDR_OMODE, 8'h41);
    cmp({15'h0, chop_en}, 16'h0001);
    cmp({15'h0, lvds_reduced}, 16'h0001);
    rchk(ADDR_OMODE, 8'h41);
    // eight warm-up edges flush any count left from the old ratio
    for (int d = 7; d >= 0; d--)
    begin
      wr(ADDR_CLKDIV, 8'(d));
      for (int i = 0; i < 2 * d + 10; i++)
      begin
        if (i == 8)
          stb_cnt = 0;
        smp_clk_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        smp_clk_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
      end
      repeat (8) @(posedge clk_sys);
      cmp(16'(stb_cnt), 16'h0002);
    end
    sx(14'h0123, 14'h0123);
    wr(ADDR_OFFS, 8'hFF);
    sx(14'h0122, 14'h0122);
    wr(ADDR_OMODE, 8'h40);
    sx(14'h2122, 14'h2122);
    wr(ADDR_OMODE, 8'h45);
    sx(14'h3EDD, 14'h3EDD);
    wr(ADDR_OMODE, 8'h41);
    for (int k = 0; k < 5; k++)
    begin
      wr(ADDR_TEST, fc[k]);
      sx(fw[k], fw[k]);
    end
    alt(8'h07, 14'h0000);
    alt(8'h0C, 14'h0F33);
    alt(8'h04, 14'h2AAA);
    wr(ADDR_TEST, 8'h0B);
    sx(14'h0001, 14'h0001);
    sx(14'h0002, 14'h0002);
    pn(8'h25);
    pn(8'h16);
    wr(ADDR_TEST, 8'h41);
    sx(14'h2000, 14'h2000);
    sx(14'h2000, 14'h2000);
    wr(ADDR_TEST, 8'h08);
    sx(14'h2969, 14'h2969);
    sx(14'h2969, 14'h2969);
    wr(ADDR_TEST, 8'h48);
    sx(14'h2969, 14'h2969);
    sx(14'h048E, 14'h048E);
    wr(ADDR_TEST, 8'h88);
    sx(14'h2969, 14'h2969);
    sx(14'h0000, 14'h0000);
    wr(ADDR_TEST, 8'hC8);
    sx(14'h2969, 14'h2969);
    sx(14'h048E, 14'h048E);
    sx(14'h0000, 14'h0000);
    wr(ADDR_TEST, 8'h00);
    wr(ADDR_IDX1, 8'h01);
    wr(ADDR_IDX2, 8'h00);
    wr(ADDR_TEST, 8'h02);
    sx(14'h3FFF, 14'h0122);
    rchk(ADDR_TEST, 8'h02);
    wr(ADDR_IDX1, 8'h3F);
    wr(ADDR_IDX2, 8'h0F);
    rchk(ADDR_TEST, 8'h02);
    give_verdict();
  end
endmodule
bind aotc_top aotc_top_assertions aotc_top_assertions_inst (.clk_sys(clk_sys), .rst(rst),
  .ce(ce), .csb_pin(csb_pin), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n), .smp_stb(smp_stb),
  .ch_valid(ch_valid), .ch_data(ch_data), .chop_en(chop_en), .lvds_reduced(lvds_reduced));
`default_nettype wire
